// ---- hdl/scs_map.vh ----
// Register offsets, field positions, reset values and timing counts
`ifndef SCS_MAP_VH
`define SCS_MAP_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SCS_OFF_CTRL 12'h000
`define SCS_OFF_CTRL_TWO 12'h004
`define SCS_OFF_TRIM 12'h008
`define SCS_OFF_TIMER_CTRL 12'h00C
`define SCS_OFF_STATUS 12'h010
// ****************************************************************
// Field positions
// ****************************************************************
`define SCS_SEL_LSB 0
`define SCS_STABLE_BIT 2
`define SCS_FREQ_LSB 4
`define SCS_RUN_BIT 2
`define SCS_LOWSRC_BIT 7
`define SCS_SECEN_BIT 3
// ****************************************************************
// Reset values
// ****************************************************************
`define SCS_SEL_RST 2'h0
`define SCS_FREQ_RST 3'h3
`define SCS_RUN_RST 1'h1
// ****************************************************************
// Select and mode encodings
// ****************************************************************
`define SCS_SEL_PRIMARY 2'h0
`define SCS_SEL_SECONDARY 2'h1
`define SCS_FREQ_SLOW 3'h0
`define SCS_MODE_LP 4'h0
`define SCS_MODE_XT 4'h1
`define SCS_MODE_HS 4'h2
`define SCS_MODE_RC 4'h3
`define SCS_MODE_EC 4'h4
`define SCS_GAIN_OFF 2'h0
`define SCS_GAIN_LOW 2'h1
`define SCS_GAIN_MID 2'h2
`define SCS_GAIN_HIGH 2'h3
// ****************************************************************
// Timing
// ****************************************************************
`define SCS_STABLE_NS 2000
`define SCS_CLK_NS 50
`define SCS_STABLE_CYC ((`SCS_STABLE_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`endif

// ---- hdl/scs_clock_select.v ----
// Clock source selection and primary oscillator control with APB access
`timescale 1ns/1ps
`include "scs_map.vh"

// Notes on behaviour
// RL1 - Select 1x routes the internal oscillator, 01 the secondary, 00 the primary.
// RL2 - The select field resets to 00 and keeps it until software writes it.
// RL3 - The slow internal oscillator is used only for code 000 with source bit clear.
// RL4 - A four-bit configuration field sets the primary oscillator mode.
// RL5 - The run-control bit acts only while the software-control bit is set.
// RL6 - With control allowed, run bit set keeps the primary running, clear stops it unless it is selected or pending as selected.
// RL7 - The primary never stops while it is the selected system clock.
// RL8 - Amplifier gain is low for LP, medium for XT and high for HS mode.
// RL9 - Code 111 is 16 MHz halving to 250 kHz at 001, 000 is 31 kHz, reset is 011.
// RL10 - The slow internal oscillator gives 31 kHz and also feeds the timers.
// RL11 - The secondary oscillator runs when its timer control enable bit is set.
// RL12 - A read-only flag reports that the fast internal oscillator is stable.
// RL13 - Source changes switch over only after the new source is synchronised.
// RL14 - Without software control the primary runs whenever not asleep.
module scs_clock_select #(
  parameter STABLE_CYC = `SCS_STABLE_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [3:0] primary_mode_cfg,
  input wire primary_sw_ctrl_allow,
  input wire sleep_req,
  input wire lfosc_need,
  input wire src_ready_async,
  output reg [1:0] active_src,
  output reg use_slow_internal_osc,
  output reg [2:0] active_freq,
  output reg primary_osc_en,
  output reg [1:0] amp_gain,
  output reg slow_internal_osc_en,
  output reg fast_internal_osc_en,
  output reg secondary_osc_en,
  output reg fast_osc_stable_flag
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [1:0] sys_clk_select;
  reg [2:0] intosc_freq_select;
  reg lowfreq_source_select;
  reg primary_osc_run;
  reg secondary_osc_enable;
  reg [1:0] pend_src;
  reg [2:0] pend_freq;
  reg pend_slow;
  reg switching;
  reg rdy_meta;
  reg rdy_sync;
  reg [15:0] stable_cnt;
  reg [31:0] next_prdata;

  wire wr = psel & penable & pwrite;
  wire addr_ok = (paddr == `SCS_OFF_CTRL) ||
                 (paddr == `SCS_OFF_CTRL_TWO) ||
                 (paddr == `SCS_OFF_TRIM) ||
                 (paddr == `SCS_OFF_TIMER_CTRL) ||
                 (paddr == `SCS_OFF_STATUS);
  wire want_slow = (intosc_freq_select == `SCS_FREQ_SLOW) &&
                   !lowfreq_source_select; // see RL3
  wire req_change = (sys_clk_select != active_src) ||
                    (intosc_freq_select != active_freq) ||
                    ((want_slow & sys_clk_select[1]) !=
                     use_slow_internal_osc); // slow only counts when internal

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_select <= `SCS_SEL_RST; // see RL2
      intosc_freq_select <= `SCS_FREQ_RST; // see RL9
      lowfreq_source_select <= 1'b0;
      primary_osc_run <= `SCS_RUN_RST;
      secondary_osc_enable <= 1'b0;
    end else if (wr) begin
      if (paddr == `SCS_OFF_CTRL) begin
        sys_clk_select <= pwdata[`SCS_SEL_LSB +: 2]; // see RL2
        intosc_freq_select <= pwdata[`SCS_FREQ_LSB +: 3];
      end else if (paddr == `SCS_OFF_CTRL_TWO) begin
        primary_osc_run <= pwdata[`SCS_RUN_BIT];
      end else if (paddr == `SCS_OFF_TRIM) begin
        lowfreq_source_select <= pwdata[`SCS_LOWSRC_BIT];
      end else if (paddr == `SCS_OFF_TIMER_CTRL) begin
        secondary_osc_enable <= pwdata[`SCS_SECEN_BIT];
      end
    end
  end

  // Read mux; status word shows the source actually in use
  always @* begin
    next_prdata = 32'h0000_0000;
    if (paddr == `SCS_OFF_CTRL) begin
      next_prdata[`SCS_SEL_LSB +: 2] = sys_clk_select;
      next_prdata[`SCS_STABLE_BIT] = fast_osc_stable_flag; // see RL12
      next_prdata[`SCS_FREQ_LSB +: 3] = intosc_freq_select;
    end else if (paddr == `SCS_OFF_CTRL_TWO) begin
      next_prdata[`SCS_RUN_BIT] = primary_osc_run;
    end else if (paddr == `SCS_OFF_TRIM) begin
      next_prdata[`SCS_LOWSRC_BIT] = lowfreq_source_select;
    end else if (paddr == `SCS_OFF_TIMER_CTRL) begin
      next_prdata[`SCS_SECEN_BIT] = secondary_osc_enable;
    end else if (paddr == `SCS_OFF_STATUS) begin
      next_prdata[1:0] = active_src;
      next_prdata[2] = use_slow_internal_osc;
      next_prdata[6:4] = active_freq;
      next_prdata[7] = switching;
    end
  end

  // Read data registered in the setup cycle so it stands in the access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prdata <= next_prdata;
    end
  end

  // ****************************************************************
  // Glitch-free switch-over
  // ****************************************************************
  // Ready from the analog clock mux crosses domains, so two flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_meta <= 1'b0;
      rdy_sync <= 1'b0;
    end else begin
      rdy_meta <= src_ready_async;
      rdy_sync <= rdy_meta;
    end
  end

  // Capture the request, then commit only when the new source is ready;
  // the old source stays in use meanwhile so no runt pulse appears
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_src <= `SCS_SEL_RST;
      active_freq <= `SCS_FREQ_RST;
      use_slow_internal_osc <= 1'b0;
      pend_src <= `SCS_SEL_RST;
      pend_freq <= `SCS_FREQ_RST;
      pend_slow <= 1'b0;
      switching <= 1'b0;
    end else if (!switching) begin
      if (req_change) begin
        pend_src <= sys_clk_select;
        pend_freq <= intosc_freq_select;
        pend_slow <= want_slow;
        switching <= 1'b1;
      end
    end else if (rdy_sync) begin
      active_src <= pend_src; // see RL1, RL13
      active_freq <= pend_freq;
      use_slow_internal_osc <= pend_slow & pend_src[1]; // see RL3
      switching <= 1'b0;
    end
  end

  // ****************************************************************
  // Oscillator enables
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_osc_en <= 1'b1;
      amp_gain <= `SCS_GAIN_OFF;
      slow_internal_osc_en <= 1'b0;
      fast_internal_osc_en <= 1'b0;
      secondary_osc_en <= 1'b0;
    end else begin
      // Primary kept alive while selected or pending as selected
      if (active_src == `SCS_SEL_PRIMARY ||
          (switching && pend_src == `SCS_SEL_PRIMARY)) begin
        primary_osc_en <= 1'b1; // see RL7
      end else if (primary_sw_ctrl_allow) begin
        primary_osc_en <= primary_osc_run; // see RL5, RL6
      end else begin
        primary_osc_en <= ~sleep_req; // see RL14
      end
      case (primary_mode_cfg) // see RL4, RL8
        `SCS_MODE_LP: amp_gain <= `SCS_GAIN_LOW;
        `SCS_MODE_XT: amp_gain <= `SCS_GAIN_MID;
        `SCS_MODE_HS: amp_gain <= `SCS_GAIN_HIGH;
        default: amp_gain <= `SCS_GAIN_OFF;
      endcase
      // Slow oscillator also serves the timers and monitor
      slow_internal_osc_en <= lfosc_need |
        (sys_clk_select[1] & want_slow); // see RL10
      fast_internal_osc_en <= sys_clk_select[1] & ~want_slow;
      secondary_osc_en <= secondary_osc_enable; // see RL11
    end
  end

  // Stable flag after a settle count of the fast oscillator
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_cnt <= 16'h0000;
      fast_osc_stable_flag <= 1'b0;
    end else if (!fast_internal_osc_en) begin
      stable_cnt <= 16'h0000;
      fast_osc_stable_flag <= 1'b0;
    end else if (stable_cnt >= STABLE_CYC[15:0] - 16'h0001) begin
      fast_osc_stable_flag <= 1'b1; // see RL12
    end else begin
      stable_cnt <= stable_cnt + 16'h0001;
    end
  end

endmodule

// ---- verif/scs_clock_select_properties.sv ----
// Port checker for the clock source select block
`timescale 1ns/1ps
`include "scs_map.vh"
module scs_checker #(
  parameter STABLE_CYC = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pslverr,
  input wire [3:0] primary_mode_cfg,
  input wire primary_sw_ctrl_allow,
  input wire sleep_req,
  input wire src_ready_async,
  input wire [1:0] active_src,
  input wire use_slow_internal_osc,
  input wire [2:0] active_freq,
  input wire primary_osc_en,
  input wire [1:0] amp_gain,
  input wire fast_internal_osc_en,
  input wire secondary_osc_en,
  input wire fast_osc_stable_flag
);
  reg [7:0] on_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since the fast oscillator was enabled, saturating
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      on_cnt <= 8'h00;
    else
      on_cnt <= fast_internal_osc_en ? on_cnt + {7'h00, on_cnt != 8'hFF} : 8'h00;
  end
  // Gain is judged only once mode and oscillator have settled
  property p_gain(m, g);
    $past(presetn) && primary_osc_en && $stable(primary_mode_cfg) &&
      primary_mode_cfg == m |-> amp_gain == g;
  endproperty
  a_gain_low: assert property (p_gain(`SCS_MODE_LP, `SCS_GAIN_LOW))
    else $error("low gain mode wrong");
  a_gain_mid: assert property (p_gain(`SCS_MODE_XT, `SCS_GAIN_MID))
    else $error("medium gain mode wrong");
  a_gain_high: assert property (p_gain(`SCS_MODE_HS, `SCS_GAIN_HIGH))
    else $error("high gain mode wrong");
  a_primary_kept: assert property (active_src == `SCS_SEL_PRIMARY &&
    !sleep_req && !$past(sleep_req) |-> primary_osc_en)
    else $error("primary stopped while selected");
  a_no_sw_ctrl: assert property ($past(presetn) && !primary_sw_ctrl_allow &&
    active_src != `SCS_SEL_PRIMARY && $stable(active_src) &&
    $stable(primary_sw_ctrl_allow) && $stable(sleep_req)
    |-> primary_osc_en == !sleep_req) else $error("primary not awake-driven");
  a_stop_cause: assert property (!primary_osc_en && !sleep_req &&
    !$past(sleep_req) |-> $past(primary_sw_ctrl_allow))
    else $error("primary stopped without control");
  a_slow_freq: assert property (use_slow_internal_osc |->
    active_freq == `SCS_FREQ_SLOW) else $error("slow osc at wrong code");
  a_src_synced: assert property ($changed(active_src) |->
    $past(src_ready_async, 2)) else $error("source changed before ready");
  a_sec_by_write: assert property ($changed(secondary_osc_en) |-> $past(psel &&
    penable && pwrite && paddr == `SCS_OFF_TIMER_CTRL, 2))
    else $error("secondary enable moved alone");
  a_stable_wait: assert property ($rose(fast_osc_stable_flag) |->
    on_cnt >= STABLE_CYC - 1) else $error("stable flag too early");
  c_internal: cover property (active_src == 2'h2 && use_slow_internal_osc);
  c_stable: cover property ($rose(fast_osc_stable_flag));
  c_error: cover property (pslverr);
endmodule
bind scs_clock_select scs_checker #(.STABLE_CYC(STABLE_CYC)) chk_i (.*);

// ---- verif/system_clock_source_select_bench.sv ----
// Directed register-level bench for the clock source select block
`timescale 1ns/1ps
`include "scs_map.vh"
module system_clock_source_select_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic pready, pslverr, rerr;
  logic [3:0] primary_mode_cfg = 0;
  logic primary_sw_ctrl_allow = 0, sleep_req = 0;
  logic lfosc_need = 0, src_ready_async = 0;
  logic [1:0] active_src, amp_gain;
  logic [2:0] active_freq;
  logic use_slow_internal_osc, primary_osc_en, slow_internal_osc_en;
  logic fast_internal_osc_en, secondary_osc_en, fast_osc_stable_flag;
  int bad_count = 0, checks_done = 0;
  scs_clock_select #(.STABLE_CYC(4)) uut (.*);
  initial begin
    forever #25 pclk = ~pclk;
  end
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // No wait count is assumed; the bound only guards a hang
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) bad_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_st(input logic [31:0] m, e);
    for (int i = 0; i < 30 && (rdat & m) !== e; i++) begin
      xfer(1'b0, `SCS_OFF_STATUS, 32'h0);
    end
    chk("status", e, rdat & m);
  endtask
  // Source change: ready is raised as soon as the control write completes, a cycle before switching is set
  task automatic sw(input logic [31:0] d, m, e);
    xfer(1'b1, `SCS_OFF_CTRL, d);
    rdat = ~e;
    src_ready_async <= 1'b1;
    wait_st(m, e);
    src_ready_async <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count++;
    conclude;
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, `SCS_OFF_CTRL, 32'h0);
    chk("ctrl", 32'h30, rdat & 32'h73);
    xfer(1'b0, `SCS_OFF_CTRL_TWO, 32'h0);
    chk("run", 32'h4, rdat & 32'h4);
    chk("stable", 1'b0, fast_osc_stable_flag);
    for (int i = 0; i < 5; i++) begin
      primary_mode_cfg <= i[3:0];
      repeat (3) @(posedge pclk);
      chk("gain", i == 0 ? `SCS_GAIN_LOW : i == 1 ? `SCS_GAIN_MID :
        i == 2 ? `SCS_GAIN_HIGH : `SCS_GAIN_OFF, amp_gain);
    end
    xfer(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {rdat[30:0], rerr});
    primary_sw_ctrl_allow <= 1'b1;
    xfer(1'b1, `SCS_OFF_CTRL_TWO, 32'h0);
    repeat (2) @(posedge pclk);
    chk("kept on", 1'b1, primary_osc_en);
    sw(32'h31, 32'h3, 32'h1);
    chk("stopped", 1'b0, primary_osc_en);
    xfer(1'b1, `SCS_OFF_CTRL_TWO, 32'h4);
    repeat (2) @(posedge pclk);
    chk("restarted", 1'b1, primary_osc_en);
    xfer(1'b1, `SCS_OFF_CTRL_TWO, 32'h0);
    primary_sw_ctrl_allow <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("awake run", 1'b1, primary_osc_en);
    sleep_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("asleep", 1'b0, primary_osc_en);
    sleep_req <= 1'b0;
    sw(32'h02, 32'h77, 32'h06);
    chk("slow", 1'b1, use_slow_internal_osc);
    xfer(1'b1, `SCS_OFF_TRIM, 32'h80);
    src_ready_async <= 1'b1;
    wait_st(32'h77, 32'h02);
    src_ready_async <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("fast", 2'h2, {fast_internal_osc_en, use_slow_internal_osc});
    sw(32'h72, 32'h77, 32'h72);
    repeat (6) @(posedge pclk);
    chk("stable", 1'b1, fast_osc_stable_flag);
    lfosc_need <= 1'b1;
    xfer(1'b1, `SCS_OFF_TIMER_CTRL, 32'h8);
    repeat (2) @(posedge pclk);
    chk("timer osc", 2'h3, {secondary_osc_en, slow_internal_osc_en});
    xfer(1'b1, `SCS_OFF_TIMER_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    chk("timer off", 1'b0, secondary_osc_en);
    sw(32'h70, 32'h3, 32'h0);
    chk("primary", 2'h0, active_src);
    conclude;
  end
endmodule
